/* File: rtl/sxc_pkg.sv */
package sxc_pkg;
  // configuration register indices
  localparam logic [7:0] IDX_PAR_SER      = 8'h04;
  localparam logic [7:0] IDX_FDC_IDE      = 8'h05;
  localparam logic [7:0] IDX_DRV_TYPES    = 8'h06;
  localparam logic [7:0] IDX_AUTOPWR      = 8'h07;
  localparam logic [7:0] IDX_AUX_LOW      = 8'h08;
  localparam logic [7:0] IDX_AUX_HIGH     = 8'h09;
  localparam logic [7:0] IDX_ECP_THR      = 8'h0a;
  // reset values
  localparam logic [7:0] RST_PAR_SER      = 8'h00;
  localparam logic [7:0] RST_FDC_IDE      = 8'h00;
  localparam logic [7:0] RST_DRV_TYPES    = 8'hff;
  localparam logic [7:0] RST_AUTOPWR      = 8'h00;
  localparam logic [7:0] RST_AUX          = 8'h00;
  localparam logic [7:0] RST_ECP_THR      = 8'h00;
  // writable bit masks, all other positions read zero
  localparam logic [7:0] MSK_PAR_SER      = 8'h7f;
  localparam logic [7:0] MSK_FDC_IDE      = 8'h7c;
  localparam logic [7:0] MSK_AUTOPWR      = 8'hf1;
  localparam logic [7:0] MSK_AUX_LOW      = 8'h0f;
  localparam logic [7:0] MSK_AUX_HIGH     = 8'hc7;
  localparam logic [7:0] MSK_ECP_THR      = 8'hcf;
  // field positions
  localparam int PS_MODE_LO   = 0;
  localparam int PS_MIDI1     = 4;
  localparam int PS_MIDI2     = 5;
  localparam int FD_DMA       = 2;
  localparam int FD_DEN_LO    = 3;
  localparam int FD_SWAP      = 5;
  localparam int FD_EXT4      = 6;
  localparam int AP_BOOT      = 0;
  localparam int AP_PAR       = 4;
  localparam int AP_U2        = 5;
  localparam int AP_U1        = 6;
  localparam int AP_FDC       = 7;
  localparam int AX_CFG_LO    = 6;
  // ecp extended-control mode codes
  localparam logic [2:0] ECR_SPP = 3'h0;
  localparam logic [2:0] ECR_EPP = 3'h4;
  // uart reference dividers
  localparam logic [3:0] DIV_STD  = 4'hd;
  localparam logic [3:0] DIV_MIDI = 4'hc;

  typedef enum logic [1:0] {
    SXC_PM_SPP, SXC_PM_EPP, SXC_PM_ECP, SXC_PM_ECPEPP
  } sxc_pmode_t;

  typedef enum logic [1:0] {
    SXC_AX_OFF, SXC_AX_BYTE, SXC_AX_BLK8, SXC_AX_BLK16
  } sxc_axcfg_t;

  // host configuration access
  typedef struct packed {
    logic       cfg_mode;
    logic       idx_wr;
    logic       dat_wr;
    logic       dat_rd;
    logic [7:0] wdata;
  } sxc_cfg_req_t;

  // floppy controller raw signals
  typedef struct packed {
    logic [1:0] drv_sel;
    logic [1:0] motor;
    logic       density;
    logic       dma_req;
    logic       irq;
    logic       byte_xfer;
    logic       fifo_en;
  } sxc_fdc_raw_t;
endpackage

/* File: rtl/sxc_midi_div.sv */
`timescale 1ns/1ps
`default_nettype none
// reference divider for one uart: /13 standard, /12 midi
module sxc_midi_div (
  input  wire logic ref_clk_in,  // clock
  input  wire logic sys_rst_in,  // sync reset
  input  wire logic clk_en_in,   // freeze when low
  input  wire logic ref_tick_in, // 24 mhz reference tick
  input  wire logic midi_in,     // 1 selects /12
  output logic      tick_out     // divided tick, registered
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } sxc_div_st_t;

  sxc_div_st_t st_r;  // state
  sxc_div_st_t st_nxt; // next state
  logic [3:0]  lim;   // terminal count

  // divide count chosen by select bit; 12 gives 2 mhz, /16 later 125 khz
  always_comb
  begin
    st_nxt = st_r;
    lim    = midi_in ? sxc_pkg::DIV_MIDI : sxc_pkg::DIV_STD;
    st_nxt.tick = 1'b0;
    if (ref_tick_in)
    begin
      if (st_r.cnt >= lim - 4'h1)
      begin
        st_nxt.cnt  = 4'h0;
        st_nxt.tick = 1'b1;
      end
      else
        st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  // register
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      st_r <= '0;
    else if (clk_en_in)
      st_r <= st_nxt;
  end

  assign tick_out = st_r.tick;
endmodule
`default_nettype wire

/* File: rtl/sxc_config_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module sxc_config_bank (
  input  wire logic                  ref_clk_in,     // 125 mhz clock
  input  wire logic                  sys_rst_in,     // sync reset, por or hw
  input  wire logic                  clk_en_in,      // freeze when low
  input  wire sxc_pkg::sxc_cfg_req_t cfg_in,         // host config access
  input  wire logic [10:0]           host_addr_in,   // isa address pins
  input  wire logic                  upper_address_select_n_in, // pin
  input  wire logic                  ref_tick_in,    // 24 mhz tick
  input  wire logic [2:0]            ecr_mode_in,    // ecp ecr mode field
  input  wire sxc_pkg::sxc_fdc_raw_t fdc_in,         // fdc core signals
  output logic [7:0]                 rdata_out,      // config read data
  output logic                       aux_address_decode_out, // aux hit
  output logic [1:0]                 drv_sel_out,    // drive selects
  output logic [1:0]                 motor_out,      // motor selects
  output logic                       external_four_drive_decode_out, // enc
  output logic                       density_out,    // density pin
  output logic                       floppy_dma_request_out, // drq pin
  output logic                       floppy_interrupt_request_out, // irq
  output logic                       epp_active_out, // epp engine on
  output logic                       spp_active_out, // spp engine on
  output logic                       ecp_active_out, // ecp engine on
  output logic [3:0]                 ecp_threshold_out, // fifo threshold
  output logic [1:0]                 ir_mux_out,     // ir pin mux
  output logic [3:0]                 autopower_out,  // fdc,u1,u2,par
  output logic                       boot_drive_b_out, // boot from b
  output logic [7:0]                 drive_types_out, // drive type codes
  output logic [1:0]                 uart_tick_out   // divided uart ticks
);
  // all register state in one struct
  typedef struct packed {
    logic [7:0]  index;      // config index register
    logic [7:0]  par_ser;    // parallel/serial setup
    logic [7:0]  fdc_ide;    // floppy/ide setup
    logic [7:0]  drv_types;  // drive types
    logic [7:0]  autopwr;    // powerdown and boot
    logic [7:0]  aux_low;    // aux base low
    logic [7:0]  aux_high;   // aux base high/config
    logic [7:0]  ecp_thr;    // threshold and ir mux
    logic [7:0]  rdata;      // read data
    logic [1:0]  ucs_sync;   // upper select synchroniser
    logic [21:0] addr_sync;  // two stage address sync
    logic        aux_hit;    // aux decode output
    logic [1:0]  drv_sel;    // drive selects out
    logic [1:0]  motor;      // motor out
    logic        ext4;       // encoded select flag
    logic        density;    // density out
    logic        drq;        // dma request out
    logic        irq;        // interrupt out
    logic        epp;        // epp enable
    logic        spp;        // spp enable
    logic        ecp;        // ecp enable
  } sxc_st_t;

  sxc_st_t              st_r;   // current state
  sxc_st_t              st_nxt; // next state
  sxc_pkg::sxc_pmode_t  pmode;  // parallel extended mode
  sxc_pkg::sxc_axcfg_t  axcfg;  // aux decoder config
  logic [10:0]          abase;  // aux decode base
  logic [10:0]          addr_s; // synchronised address
  logic [1:0]           ticks;  // divider ticks

  // masked write: read-only positions stay zero
  function automatic logic [7:0] mwr(input logic [7:0] d,
                                     input logic [7:0] m);
    mwr = d & m;
  endfunction

  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    pmode  = sxc_pkg::sxc_pmode_t'(st_r.par_ser[1:0]);
    axcfg  = sxc_pkg::sxc_axcfg_t'(st_r.aux_high[7:6]);
    abase  = {st_r.aux_high[2:0], st_r.aux_low[3:0], 4'h0};
    addr_s = st_r.addr_sync[21:11];
    // pin synchronisers: first stage feeds only the second
    st_nxt.ucs_sync  = {st_r.ucs_sync[0], upper_address_select_n_in};
    st_nxt.addr_sync = {st_r.addr_sync[10:0], host_addr_in};
    // host config access only in config mode
    if (cfg_in.cfg_mode)
    begin
      if (cfg_in.idx_wr)
        st_nxt.index = cfg_in.wdata;
      else if (cfg_in.dat_wr)
      begin
        case (st_r.index)
          sxc_pkg::IDX_PAR_SER:
            st_nxt.par_ser = mwr(cfg_in.wdata, sxc_pkg::MSK_PAR_SER);
          sxc_pkg::IDX_FDC_IDE:
            st_nxt.fdc_ide = mwr(cfg_in.wdata, sxc_pkg::MSK_FDC_IDE);
          sxc_pkg::IDX_DRV_TYPES:
            st_nxt.drv_types = cfg_in.wdata;
          sxc_pkg::IDX_AUTOPWR:
            st_nxt.autopwr = mwr(cfg_in.wdata, sxc_pkg::MSK_AUTOPWR);
          sxc_pkg::IDX_AUX_LOW:
            st_nxt.aux_low = mwr(cfg_in.wdata, sxc_pkg::MSK_AUX_LOW);
          sxc_pkg::IDX_AUX_HIGH:
            st_nxt.aux_high = mwr(cfg_in.wdata, sxc_pkg::MSK_AUX_HIGH);
          sxc_pkg::IDX_ECP_THR:
            st_nxt.ecp_thr = mwr(cfg_in.wdata, sxc_pkg::MSK_ECP_THR);
          default:
            st_nxt.index = st_r.index; // unmapped index, write dropped
        endcase
      end
    end
    // read path, zero outside config mode or unmapped index
    st_nxt.rdata = 8'h00;
    if (cfg_in.cfg_mode && cfg_in.dat_rd)
    begin
      case (st_r.index)
        sxc_pkg::IDX_PAR_SER:   st_nxt.rdata = st_r.par_ser;
        sxc_pkg::IDX_FDC_IDE:   st_nxt.rdata = st_r.fdc_ide;
        sxc_pkg::IDX_DRV_TYPES: st_nxt.rdata = st_r.drv_types;
        sxc_pkg::IDX_AUTOPWR:   st_nxt.rdata = st_r.autopwr;
        sxc_pkg::IDX_AUX_LOW:   st_nxt.rdata = st_r.aux_low;
        sxc_pkg::IDX_AUX_HIGH:  st_nxt.rdata = st_r.aux_high;
        sxc_pkg::IDX_ECP_THR:   st_nxt.rdata = st_r.ecp_thr;
        default:                st_nxt.rdata = 8'h00;
      endcase
    end
    // parallel engine selection from mode field and ecr
    st_nxt.spp = 1'b0;
    st_nxt.epp = 1'b0;
    st_nxt.ecp = 1'b0;
    case (pmode)
      sxc_pkg::SXC_PM_SPP:
        st_nxt.spp = 1'b1;
      sxc_pkg::SXC_PM_EPP:
      begin
        st_nxt.spp = 1'b1;
        st_nxt.epp = 1'b1;
      end
      sxc_pkg::SXC_PM_ECP:
      begin
        st_nxt.ecp = 1'b1;
        st_nxt.spp = (ecr_mode_in == sxc_pkg::ECR_SPP);
      end
      sxc_pkg::SXC_PM_ECPEPP:
      begin
        st_nxt.ecp = 1'b1;
        st_nxt.spp = (ecr_mode_in == sxc_pkg::ECR_SPP);
        st_nxt.epp = (ecr_mode_in == sxc_pkg::ECR_EPP);
      end
      default:
        st_nxt.spp = 1'b1;
    endcase
    // drive select path: swap first, then optional encoding
    st_nxt.drv_sel = fdc_in.drv_sel;
    st_nxt.motor   = fdc_in.motor;
    if (st_r.fdc_ide[sxc_pkg::FD_SWAP])
    begin
      st_nxt.drv_sel = {fdc_in.drv_sel[0], fdc_in.drv_sel[1]};
      st_nxt.motor   = {fdc_in.motor[0], fdc_in.motor[1]};
    end
    // ecp settings only support two direct drives
    st_nxt.ext4 = st_r.fdc_ide[sxc_pkg::FD_EXT4] && !st_nxt.ecp;
    // density override
    case (st_r.fdc_ide[sxc_pkg::FD_DEN_LO +: 2])
      2'b10:   st_nxt.density = 1'b1;
      2'b11:   st_nxt.density = 1'b0;
      default: st_nxt.density = fdc_in.density; // normal, 01 reserved
    endcase
    // non-burst strobes each byte while fifo on
    if (st_r.fdc_ide[sxc_pkg::FD_DMA] && fdc_in.fifo_en)
    begin
      st_nxt.drq = fdc_in.byte_xfer;
      st_nxt.irq = fdc_in.byte_xfer;
    end
    else
    begin
      st_nxt.drq = fdc_in.dma_req;
      st_nxt.irq = fdc_in.irq;
    end
    // aux decoder; pins are sampled after sync, so answer lags three cycles
    st_nxt.aux_hit = 1'b0;
    if (!st_r.ucs_sync[1])
    begin
      case (axcfg)
        sxc_pkg::SXC_AX_BYTE:
          st_nxt.aux_hit = (addr_s == abase);
        sxc_pkg::SXC_AX_BLK8:
          st_nxt.aux_hit = (addr_s[10:3] == abase[10:3]);
        sxc_pkg::SXC_AX_BLK16:
          st_nxt.aux_hit = (addr_s[10:4] == abase[10:4]);
        default:
          st_nxt.aux_hit = 1'b0;
      endcase
    end
  end

  // state register; every reset is treated as por or hardware reset
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      st_r           <= '0;
      st_r.par_ser   <= sxc_pkg::RST_PAR_SER;
      st_r.fdc_ide   <= sxc_pkg::RST_FDC_IDE;
      st_r.drv_types <= sxc_pkg::RST_DRV_TYPES;
      st_r.autopwr   <= sxc_pkg::RST_AUTOPWR;
      st_r.aux_low   <= sxc_pkg::RST_AUX;
      st_r.aux_high  <= sxc_pkg::RST_AUX;
      st_r.ecp_thr   <= sxc_pkg::RST_ECP_THR;
      st_r.ucs_sync  <= 2'b11;
      st_r.spp       <= 1'b1;
    end
    else if (clk_en_in)
      st_r <= st_nxt;
  end

  // one divider per serial port
  for (genvar g = 0; g < 2; g++)
  begin : g_div
    sxc_midi_div u_div (
      .ref_clk_in  (ref_clk_in),
      .sys_rst_in  (sys_rst_in),
      .clk_en_in   (clk_en_in),
      .ref_tick_in (ref_tick_in),
      .midi_in     (st_r.par_ser[sxc_pkg::PS_MIDI1 + g]),
      .tick_out    (ticks[g])
    );
  end

  // outputs straight from flops
  assign rdata_out                      = st_r.rdata;
  assign aux_address_decode_out         = st_r.aux_hit;
  assign drv_sel_out                    = st_r.drv_sel;
  assign motor_out                      = st_r.motor;
  assign external_four_drive_decode_out = st_r.ext4;
  assign density_out                    = st_r.density;
  assign floppy_dma_request_out         = st_r.drq;
  assign floppy_interrupt_request_out   = st_r.irq;
  assign epp_active_out                 = st_r.epp;
  assign spp_active_out                 = st_r.spp;
  assign ecp_active_out                 = st_r.ecp;
  assign ecp_threshold_out              = st_r.ecp_thr[3:0];
  assign ir_mux_out                     = st_r.ecp_thr[7:6];
  assign autopower_out                  = st_r.autopwr[7:4];
  assign boot_drive_b_out               = st_r.autopwr[sxc_pkg::AP_BOOT];
  assign drive_types_out                = st_r.drv_types;
  assign uart_tick_out                  = ticks;
endmodule
`default_nettype wire

/* File: verification/sxc_bank_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// pin-level watch on the bank; mirrors only what pins cannot show
module sxc_bank_chk (
  input wire logic                  ref_clk_in,    // clock
  input wire logic                  sys_rst_in,    // sync reset
  input wire logic                  clk_en_in,     // enable
  input wire sxc_pkg::sxc_cfg_req_t cfg_in,        // config access
  input wire logic                  upper_address_select_n_in, // select
  input wire logic [2:0]            ecr_mode_in,   // ecr mode
  input wire sxc_pkg::sxc_fdc_raw_t fdc_in,        // fdc raw
  input wire logic [7:0]            rdata_out,     // read data
  input wire logic                  aux_address_decode_out, // aux hit
  input wire logic [1:0]            drv_sel_out,   // drive selects
  input wire logic                  external_four_drive_decode_out, // enc
  input wire logic                  density_out,   // density
  input wire logic                  floppy_dma_request_out, // drq
  input wire logic                  floppy_interrupt_request_out, // irq
  input wire logic                  epp_active_out, // epp on
  input wire logic                  spp_active_out, // spp on
  input wire logic [3:0]            autopower_out, // powerdown
  input wire logic [1:0]            ir_mux_out     // ir mux
);
  logic [7:0] idx_r; // mirrored index
  logic [7:0] fd_r;  // floppy setup mirror
  logic [1:0] md_r;  // parallel mode mirror
  // mirror kept tiny on purpose: three registers the pins hide
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      idx_r <= 8'h00;
      fd_r  <= 8'h00;
      md_r  <= 2'h0;
    end
    else if (clk_en_in && cfg_in.cfg_mode && cfg_in.idx_wr)
      idx_r <= cfg_in.wdata;
    else if (clk_en_in && cfg_in.cfg_mode && cfg_in.dat_wr)
    begin
      if (idx_r == sxc_pkg::IDX_FDC_IDE)
        fd_r <= cfg_in.wdata & sxc_pkg::MSK_FDC_IDE;
      if (idx_r == sxc_pkg::IDX_PAR_SER)
        md_r <= cfg_in.wdata[1:0];
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_rdata_pulse: assert property (
    rdata_out != 8'h00 |-> $past(clk_en_in && cfg_in.cfg_mode && cfg_in.dat_rd))
    else $error("read data outside read slot");
  // reset itself is the cause here, so it cannot disable the check
  a_reset_clear: assert property (disable iff (1'b0)
    sys_rst_in |=> autopower_out == 4'h0 && ir_mux_out == 2'h0)
    else $error("powerdown or ir mux not cleared by reset");
  a_aux_select: assert property (
    aux_address_decode_out |-> !$past(upper_address_select_n_in, 3))
    else $error("aux hit without upper select");
  a_density_force: assert property (
    $past(clk_en_in && fd_r[4]) |-> density_out == !$past(fd_r[3]))
    else $error("density not forced");
  a_drive_swap: assert property (
    $past(clk_en_in && fd_r[5] && !fd_r[6]) |-> drv_sel_out ==
    {$past(fdc_in.drv_sel[0]), $past(fdc_in.drv_sel[1])})
    else $error("drive selects not swapped");
  a_nonburst_strobe: assert property (
    $past(clk_en_in && fd_r[2] && fdc_in.fifo_en) |->
    floppy_dma_request_out == $past(fdc_in.byte_xfer) &&
    floppy_interrupt_request_out == $past(fdc_in.byte_xfer))
    else $error("per byte strobes wrong");
  a_ecp_spp: assert property (
    $past(clk_en_in && md_r[1] && ecr_mode_in == sxc_pkg::ECR_SPP)
    |-> spp_active_out)
    else $error("spp not on in ecp mode");
  a_ecp_epp: assert property (
    $past(clk_en_in && md_r == 2'h3 && ecr_mode_in == sxc_pkg::ECR_EPP)
    |-> epp_active_out)
    else $error("epp not on in ecp plus epp mode");
  a_ecp_two_drive: assert property (
    $past(clk_en_in && md_r[1]) |-> !external_four_drive_decode_out)
    else $error("encoded selects in ecp mode");
endmodule
bind sxc_config_bank sxc_bank_chk u_chk (
  .ref_clk_in, .sys_rst_in, .clk_en_in, .cfg_in,
  .upper_address_select_n_in, .ecr_mode_in, .fdc_in, .rdata_out,
  .aux_address_decode_out, .drv_sel_out, .external_four_drive_decode_out,
  .density_out, .floppy_dma_request_out, .floppy_interrupt_request_out,
  .epp_active_out, .spp_active_out, .autopower_out, .ir_mux_out
);
`default_nettype wire

/* File: verification/sxc_config_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module sxc_config_bank_tb;
  logic                  clk = 1'b0;  // 125 mhz
  logic                  rst = 1'b1;  // sync reset
  sxc_pkg::sxc_cfg_req_t cfg = '0;    // host access
  sxc_pkg::sxc_fdc_raw_t fdc = '0;    // fdc core side
  logic [10:0]           addr = '0;   // isa address
  logic                  cs_n = 1'b1; // upper select
  logic [2:0]            ecr = '0;    // ecr mode
  logic                  tick = 1'b1; // reference tick
  logic [7:0]            rd, dtyp;    // read data, drive types
  logic                  aux, ext4, den, drq, irq, epp, spp, ecp, boot;
  logic [1:0]            dsel, mot, irm, ut;
  logic [3:0]            thr, apw;
  int                    err_count = 0;
  int                    samples_checked = 0;
  initial forever #4 clk = ~clk;
  sxc_config_bank dut (.ref_clk_in(clk), .sys_rst_in(rst),
    .clk_en_in(1'b1), .cfg_in(cfg), .host_addr_in(addr),
    .upper_address_select_n_in(cs_n), .ref_tick_in(tick),
    .ecr_mode_in(ecr), .fdc_in(fdc), .rdata_out(rd),
    .aux_address_decode_out(aux), .drv_sel_out(dsel), .motor_out(mot),
    .external_four_drive_decode_out(ext4), .density_out(den),
    .floppy_dma_request_out(drq), .floppy_interrupt_request_out(irq),
    .epp_active_out(epp), .spp_active_out(spp), .ecp_active_out(ecp),
    .ecp_threshold_out(thr), .ir_mux_out(irm), .autopower_out(apw),
    .boot_drive_b_out(boot), .drive_types_out(dtyp), .uart_tick_out(ut));
  // one config bus slot, held for exactly one edge
  task automatic cyc(input logic iw, dw, dr, input logic [7:0] d);
    cfg <= '{1'b1, iw, dw, dr, d};
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] i, d);
    cyc(1'b1, 1'b0, 1'b0, i);
    cyc(1'b0, 1'b1, 1'b0, d);
    cyc(1'b0, 1'b0, 1'b0, 8'h00);
  endtask
  // read data stands one cycle only, so it is caught just after its edge
  task automatic rdr(input logic [7:0] i, output logic [7:0] v);
    cyc(1'b1, 1'b0, 1'b0, i);
    cyc(1'b0, 1'b0, 1'b1, 8'h00);
    #1 v = rd;
    cyc(1'b0, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset values, writable masks, unmapped index
  task automatic t_regs;
    logic [7:0] ix [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk [7] = '{8'h7f, 8'h7c, 8'hff, 8'hf1, 8'h0f, 8'hc7, 8'hcf};
    logic [7:0] v;
    for (int i = 0; i < 7; i++)
    begin
      rdr(ix[i], v);
      `CHK("reset value", rv[i], v)
      wr(ix[i], 8'hff);
      rdr(ix[i], v);
      `CHK("mask", mk[i], v)
    end
    `CHK("autopower", 4'hf, apw)
    `CHK("ir mux", 2'h3, irm)
    `CHK("threshold", 4'hf, thr)
    `CHK("boot b", 1'b1, boot)
    wr(8'h06, 8'h3c);
    rdr(8'h0b, v);
    `CHK("unmapped", 8'h00, v)
    `CHK("drive types", 8'h3c, dtyp)
    $display("t_regs done");
  endtask
  // writes outside configuration mode are dropped
  task automatic t_nocfg;
    logic [7:0] v;
    cfg <= '{1'b0, 1'b1, 1'b0, 1'b0, 8'h06};
    @(posedge clk);
    cfg <= '{1'b0, 1'b0, 1'b1, 1'b0, 8'h81};
    @(posedge clk);
    rdr(8'h06, v);
    `CHK("no config write", 8'h3c, v)
    $display("t_nocfg done");
  endtask
  task automatic t_fdc;
    wr(8'h04, 8'h00);
    for (int d = 0; d < 4; d++)
    begin
      wr(8'h05, 8'(d << 3));
      fdc <= '{2'b01, 2'b10, d[0], 1'b0, 1'b0, 1'b1, 1'b1};
      settle(2);
      `CHK("density", d[1] ? ~d[0] : d[0], den)
      `CHK("burst drq", 1'b0, drq)
    end
    wr(8'h05, 8'h20);
    settle(2);
    `CHK("swap", 4'h9, {dsel, mot})
    wr(8'h05, 8'h04);
    settle(2);
    `CHK("per byte", 2'h3, {drq, irq})
    wr(8'h05, 8'h40);
    settle(2);
    `CHK("ext decode", 1'b1, ext4)
    wr(8'h04, 8'h02);
    settle(2);
    `CHK("ecp two drive", 1'b0, ext4)
    $display("t_fdc done");
  endtask
  task automatic t_par;
    logic [2:0] e;
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 2; k++)
      begin
        wr(8'h04, 8'(m));
        ecr <= k ? sxc_pkg::ECR_EPP : sxc_pkg::ECR_SPP;
        settle(2);
        e = {m < 2 || k == 0, m == 1 || (m == 3 && k == 1), m > 1};
        `CHK("parallel", e, {spp, epp, ecp})
      end
    $display("t_par done");
  endtask
  // base 0x3a0, every decode shape, select both ways
  task automatic t_aux;
    logic [10:0] a;
    logic [4:0]  of [4] = '{5'd0, 5'd5, 5'd9, 5'd16};
    logic        e;
    wr(8'h08, 8'h0a);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h09, 8'(c << 6) | 8'h03);
      for (int j = 0; j < 8; j++)
      begin
        a = 11'h3a0 + 11'(of[j % 4]);
        addr <= a;
        cs_n <= j / 4;
        settle(4);
        e = j < 4 && c > 0 && a[10:4] == 7'h3a &&
            (c == 3 || (c == 2 && !a[3]) || a[3:0] == 4'h0);
        `CHK("aux decode", e, aux)
      end
    end
    $display("t_aux done");
  endtask
  task automatic gap(input int b, input int e);
    int n;
    // step off the edge so the tick is read after it settles
    #1;
    for (n = 0; n < 80 && ut[b] !== 1'b1; n++)
      settle(1);
    n = 0;
    do
    begin
      settle(1);
      n++;
    end
    while (ut[b] !== 1'b1 && n < 80);
    if (n >= 80)
    begin
      err_count++;
      stop_test();
    end
    else
      `CHK("uart gap", e, n)
  endtask
  task automatic t_div;
    wr(8'h04, 8'h10);
    gap(0, 12);
    gap(1, 13);
    wr(8'h04, 8'h20);
    gap(0, 13);
    gap(1, 12);
    $display("t_div done");
  endtask
  // second reset in mid run clears powerdown and mux bits
  task automatic t_rst2;
    logic [7:0] v;
    wr(8'h07, 8'hf1);
    wr(8'h0a, 8'hcf);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    `CHK("reset clears", 7'h00, {apw, irm, boot})
    rdr(8'h07, v);
    `CHK("reg07 reset", 8'h00, v)
    $display("t_rst2 done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_nocfg();
    t_fdc();
    t_par();
    t_aux();
    t_div();
    t_rst2();
    stop_test();
  end
endmodule
`default_nettype wire
